// file: asp_port.sv
// converter output port: parallel bits 5-7 shared with serial port options
// assumes APB on pclk; external serial clock arrives on link_sclk, gated by cs
`timescale 1ns/1ps

module asp_port (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // mode straps
  input  wire logic        serial_parallel_select,
  input  wire logic        clock_source_select,
  // shared pins: bit0 sync polarity, bit1 clock invert, bit2 read mode or chain
  input  wire logic [2:0]  shared_in,
  output logic      [2:0]  shared_out,
  output logic      [2:0]  shared_oe,
  // serial port
  input  wire logic        link_sclk,
  input  wire logic        cs_n,
  output logic             sclk_out,
  output logic             sclk_oe,
  output logic             frame_sync,
  output logic             serial_result_output
);

  // synchronised levels
  logic       ser_s;        // serial port selected
  logic       ext_s;        // external clocking selected
  logic       pol_s;        // frame sync polarity select
  logic       inv_s;        // serial clock invert
  logic       rdm_s;        // read mode
  logic       cs_n_s;       // chip select

  // converter stand-in
  logic [15:0] sample;      // value the next conversion returns
  logic [15:0] result;      // latched conversion result
  logic        busy;
  logic [5:0]  conv_cnt;

  // internal clocking frame
  asp_pkg::asp_mstate_t mstate;
  logic [15:0] m_shift;
  logic [4:0]  m_bits;
  logic [1:0]  m_div;
  logic        m_sclk;      // internal clock before inversion
  logic        m_serial_result_output;
  logic        m_serial_result_output_q;   // pin copy, aligned with the registered clock and sync

  // external clocking frame (link domain)
  logic [4:0]  l_cnt;
  logic        l_serial_result_output;

  asp_sync #(.W(6)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({serial_parallel_select, clock_source_select, shared_in, cs_n}),
    .q       ({ser_s, ext_s, rdm_s, inv_s, pol_s, cs_n_s})
  );

  // apb decode
  wire apb_setup  = psel & ~penable;
  wire apb_wr     = psel & penable & pwrite;
  wire hit_ctrl   = (paddr == asp_pkg::ASP_REG_CTRL);
  wire hit_sample = (paddr == asp_pkg::ASP_REG_SAMPLE);
  wire hit_result = (paddr == asp_pkg::ASP_REG_RESULT);
  wire hit_status = (paddr == asp_pkg::ASP_REG_STATUS);
  wire hit_any    = hit_ctrl | hit_sample | hit_result | hit_status;

  // conversion start and finish
  wire start_conv = apb_wr & hit_ctrl & pwdata[asp_pkg::ASP_CTRL_START] & ~busy;
  wire conv_done  = busy & (conv_cnt == 6'(asp_pkg::ASP_CONV_CYCLES - 1));

  // internal clocking only in serial mode with clock source low
  wire master_mode = ser_s & ~ext_s;
  // read during conversion ships the old result as conversion starts
  wire frame_rdc   = master_mode & rdm_s & start_conv;
  // read after conversion waits for the new result
  wire frame_rac   = master_mode & ~rdm_s & conv_done;
  wire frame_go    = (mstate == asp_pkg::ASP_M_IDLE) & (frame_rdc | frame_rac);
  wire [15:0] frame_word = frame_rdc ? result : sample;

  // internal clock half-period tick and edges
  wire half_tick  = (m_div == 2'(asp_pkg::ASP_SCLK_HALF - 1));
  wire fall_edge  = half_tick & m_sclk;
  wire frame_last = fall_edge & (m_bits == 5'(asp_pkg::ASP_RESULT_BITS - 1));
  wire m_active   = (mstate == asp_pkg::ASP_M_SHIFT);

  // status word
  wire [31:0] status_word = {24'h000000, ~cs_n_s, rdm_s, inv_s, pol_s, ext_s, ser_s, m_active, busy};

  wire [31:0] read_mux = hit_sample ? {16'h0000, sample} :
                         hit_result ? {16'h0000, result} :
                         hit_status ? status_word : 32'h00000000;

  // apb answer: read data captured in setup, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (apb_setup) begin
        prdata  <= read_mux;
        pslverr <= ~hit_any;   // unmapped address answers with an error
      end
    end
  end

  // sample register written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample <= asp_pkg::ASP_SAMPLE_RST;
    end else if (apb_wr & hit_sample) begin
      sample <= pwdata[15:0];
    end
  end

  // conversion timer; a start while busy is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy     <= 1'b0;
      conv_cnt <= 6'h00;
      result   <= asp_pkg::ASP_RESULT_RST;
    end else if (start_conv) begin
      busy     <= 1'b1;
      conv_cnt <= 6'h00;
    end else if (conv_done) begin
      busy   <= 1'b0;
      result <= sample;   // the result only changes here, when a conversion ends, whatever the level of cs
    end else if (busy) begin
      conv_cnt <= conv_cnt + 6'h01;
    end
  end

  // internal clocking frame state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mstate <= asp_pkg::ASP_M_IDLE;
    end else begin
      unique case (mstate)
        asp_pkg::ASP_M_IDLE: begin
          if (frame_go) begin
            mstate <= asp_pkg::ASP_M_SHIFT;
          end
        end
        asp_pkg::ASP_M_SHIFT: begin
          // abandon the frame if the mode is changed under it
          if (frame_last | ~master_mode) begin
            mstate <= asp_pkg::ASP_M_IDLE;
          end
        end
      endcase
    end
  end

  // internal clock divider and msb-first shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_div   <= 2'h0;
      m_sclk  <= 1'b0;
      m_bits  <= 5'h00;
      m_shift <= 16'h0000;
      m_serial_result_output <= 1'b0;
    end else if (frame_go) begin
      m_div   <= 2'h0;
      m_sclk  <= 1'b0;
      m_bits  <= 5'h00;
      m_shift <= {frame_word[14:0], 1'b0};
      m_serial_result_output <= frame_word[15];
    end else if (m_active) begin
      m_div <= half_tick ? 2'h0 : m_div + 2'h1;
      if (half_tick) begin
        m_sclk <= ~m_sclk;
      end
      // data moves on the falling edge so it is steady around the rising edge
      if (fall_edge) begin
        m_bits  <= m_bits + 5'h01;
        m_serial_result_output <= m_shift[15];
        m_shift <= {m_shift[14:0], 1'b0};
      end
    end else begin
      m_sclk <= 1'b0;
    end
  end

  // serial port pins in the pclk domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_out   <= 1'b0;
      sclk_oe    <= 1'b0;
      frame_sync <= 1'b0;
      m_serial_result_output_q  <= 1'b0;
    end else begin
      // data passes the same flop stage as the clock, so it moves on the pin edge where the uninverted clock falls
      m_serial_result_output_q  <= m_serial_result_output;
      sclk_out   <= m_sclk ^ inv_s;
      sclk_oe    <= master_mode;
      // sync is asserted only with internal clocking; the pin is always driven and idle shows the inactive level
      frame_sync <= (m_active & ~frame_last) ^ pol_s;
    end
  end

  // shared pins: result bits 7..5 in parallel mode, inputs in serial mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_out <= 3'h0;
      shared_oe  <= 3'h0;
    end else begin
      shared_out <= result[asp_pkg::ASP_PAR_LSB +: 3];
      shared_oe  <= {3{~ser_s}};
    end
  end

  // external clocking: cs high ends the frame, clock invert picks the updating edge
  wire link_rst_n = presetn & ~cs_n;
  wire link_clk   = link_sclk ^ shared_in[1];

  // link-side counter and data; the result word is read live and is not held while cs is low
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l_cnt   <= 5'h00;
      l_serial_result_output <= 1'b0;
    end else begin
      if (l_cnt != 5'h1f) begin
        l_cnt <= l_cnt + 5'h01;
      end
      // after the own word the chain input follows, sixteen clocks late
      if (l_cnt < 5'(asp_pkg::ASP_CHAIN_DELAY)) begin
        l_serial_result_output <= result[4'(asp_pkg::ASP_RESULT_BITS - 1) - l_cnt[3:0]];
      end else begin
        l_serial_result_output <= shared_in[2];
      end
    end
  end

  // pin carries whichever clocking owns the port
  assign serial_result_output = ext_s ? l_serial_result_output : m_serial_result_output_q;

endmodule

// file: asp_pkg.sv
// constants shared by the serial/parallel output port block
// assumes pclk at 25 MHz and a 32-bit APB slave interface
package asp_pkg;

  // register byte offsets
  localparam logic [7:0] ASP_REG_CTRL   = 8'h00;
  localparam logic [7:0] ASP_REG_SAMPLE = 8'h04;
  localparam logic [7:0] ASP_REG_RESULT = 8'h08;
  localparam logic [7:0] ASP_REG_STATUS = 8'h0c;

  // control register fields
  localparam int ASP_CTRL_START = 0;

  // status register fields
  localparam int ASP_ST_BUSY     = 0;
  localparam int ASP_ST_MREAD    = 1;
  localparam int ASP_ST_SERIAL   = 2;
  localparam int ASP_ST_EXTCLK   = 3;
  localparam int ASP_ST_SYNCPOL  = 4;
  localparam int ASP_ST_SCLKINV  = 5;
  localparam int ASP_ST_RDMODE   = 6;
  localparam int ASP_ST_CSACTIVE = 7;

  // reset values
  localparam logic [15:0] ASP_SAMPLE_RST = 16'h0000;
  localparam logic [15:0] ASP_RESULT_RST = 16'h0000;

  // result layout
  localparam int ASP_RESULT_BITS = 16;
  localparam int ASP_PAR_LSB     = 5;    // first shared parallel bit
  localparam int ASP_CHAIN_DELAY = 16;   // serial clocks before chain data

  // timing
  localparam int ASP_PCLK_NS       = 40;
  localparam int ASP_CONV_TIME_NS  = 1500;
  localparam int ASP_CONV_CYCLES   = (ASP_CONV_TIME_NS + ASP_PCLK_NS - 1) / ASP_PCLK_NS;
  localparam int ASP_SCLK_HALF     = 1;    // pclk cycles per internal sclk half period

  // internal clocking frame states
  typedef enum logic [0:0] {
    ASP_M_IDLE,
    ASP_M_SHIFT
  } asp_mstate_t;

endpackage

// file: asp_sync.sv
// two-stage synchroniser for a group of static or slow level inputs
// assumes the inputs are levels from pins outside the pclk domain
`timescale 1ns/1ps

module asp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1;   // metastable stage, read only by q

  // first flop feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule

// file: asp_port_chk.sv
// assertions on the pins of the serial/parallel port block
// assumes binding to asp_port; straps are slow levels
`timescale 1ns/1ps
module asp_port_chk (
  // apb
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  // pins
  input wire logic       serial_parallel_select,
  input wire logic       clock_source_select,
  input wire logic [2:0] shared_in,
  input wire logic [2:0] shared_oe,
  input wire logic       cs_n,
  input wire logic       sclk_out,
  input wire logic       sclk_oe,
  input wire logic       frame_sync,
  input wire logic       serial_result_output
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // frame active with the polarity taken out
  wire act = frame_sync ^ shared_in[0];
  // four cycles cover the two-flop synchroniser plus the output flop
  a_par_drive: assert property (!serial_parallel_select [*4] |-> shared_oe == 3'h7)
    else $error("shared pins not driven in parallel mode");
  a_ser_inputs: assert property (serial_parallel_select [*4] |-> shared_oe == 3'h0)
    else $error("shared pins driven in serial mode");
  a_clk_drive: assert property ((serial_parallel_select && $stable(clock_source_select)) [*4]
    |-> sclk_oe == !clock_source_select)
    else $error("serial clock drive wrong for clock source");
  a_ext_gate: assert property ((serial_parallel_select && clock_source_select) [*4] ##0 cs_n
    |-> !serial_result_output)
    else $error("serial output not gated by chip select");
  a_sclk_idle: assert property (($stable(shared_in[1:0]) && sclk_oe && !act) [*4]
    |-> sclk_out == shared_in[1])
    else $error("idle serial clock level ignores invert");
  a_frame_hold: assert property ((serial_parallel_select && $stable(shared_in[0])) [*4] ##0 $rose(act)
    |-> act [*8] ##[16:32] !act)
    else $error("frame sync length wrong");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_bad_addr: assert property (psel && penable && paddr > 8'h0c |-> pslverr)
    else $error("unmapped access without error");
endmodule
bind asp_port asp_port_chk asp_port_chk_i (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .serial_parallel_select, .clock_source_select, .shared_in, .shared_oe, .cs_n, .sclk_out, .sclk_oe,
  .frame_sync, .serial_result_output);

// file: asp_host.sv
// model of the host serial port in slave clocking
// assumes a 6 ns link clock that stands still between frames
`timescale 1ns/1ps
module asp_host (
  // link
  output logic       link_sclk,
  output logic       cs_n,
  output logic       chain,
  input  wire logic  sdo
);
  logic [23:0] got;  // bits taken from the serial output
  initial begin
    link_sclk = 1'b0;
    cs_n = 1'b1;
    chain = 1'b0;
    got = '0;
  end
  // one frame of 24 clocks; idle level follows invert so the first edge is active
  task automatic frame(input logic inv, input logic [7:0] cpat);
    link_sclk = inv;
    #5 cs_n = 1'b0;
    for (int k = 0; k < 24; k++) begin
      chain = (k >= 16) ? cpat[23-k] : ~chain;  // neighbour data after 16 clocks
      #3 link_sclk = ~link_sclk;
      #3 link_sclk = ~link_sclk;
      got = {got[22:0], sdo};  // taken on the non-active edge
    end
    #5 cs_n = 1'b1;
    chain = ~chain;  // released line does not hold its value
  endtask
endmodule

// file: tb_asp_port.sv
// self-checking bench for the serial/parallel port block
// assumes asp_port, asp_host and the checker are compiled first
`timescale 1ns/1ps
module tb_asp_port;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sps, css, link_sclk, cs_n, chain, sclk_out, sclk_oe, fsync, sdo;
  logic [2:0]  drv, sh_in, sh_out, sh_oe;
  logic [15:0] last;  // last conversion result
  int          failures, num_checks, cyc;
  // pin level: design drives where enabled, else host side
  assign sh_in = (sh_oe & sh_out) | (~sh_oe & {css ? chain : drv[2], drv[1:0]});
  asp_port asp_port_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .serial_parallel_select(sps), .clock_source_select(css), .shared_in(sh_in),
    .shared_out(sh_out), .shared_oe(sh_oe), .link_sclk, .cs_n, .sclk_out, .sclk_oe,
    .frame_sync(fsync), .serial_result_output(sdo));
  asp_host asp_host_i (.link_sclk, .cs_n, .chain, .sdo);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one apb transfer; waits on pready, the timeout bounds it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // convert a sample: write it, then set start; busy is not awaited here
  task automatic convert(input logic [15:0] s);
    apb(1'b1, asp_pkg::ASP_REG_SAMPLE, {16'h0, s});
    apb(1'b1, asp_pkg::ASP_REG_CTRL, 32'h1);
  endtask
  task automatic idle;
    do apb(1'b0, asp_pkg::ASP_REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask
  task automatic t_par;
    convert(16'h00a0);
    idle;
    check({26'h0, sh_oe, sh_out}, 32'h3d, "parallel pins");
    apb(1'b0, 8'h10, 32'h0);
    check({err, rd[30:0]}, 32'h80000000, "unmapped read");
    last = 16'h00a0;
  endtask
  // internal clock frames over every polarity, invert and read mode
  task automatic t_master;
    logic [15:0] v, s;
    int w;
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      sps <= 1'b1;
      drv <= {k[0] ^ k[1], k[1], k[0]};  // read mode apart from polarity
      repeat (6) @(posedge pclk);
      s = 16'hc3a5 ^ {4{k[3:0]}};
      convert(s);
      w = 0;
      v = '0;
      while (fsync === k[0]) begin
        @(posedge pclk);
        w++;
      end
      while (fsync !== k[0]) begin
        if ((sclk_out ^ k[1]) === 1'b0) v = {v[14:0], sdo};
        @(posedge pclk);
      end
      check({16'h0, v}, {16'h0, (k[0] ^ k[1]) ? last : s}, "frame data");
      check({31'h0, w >= 30}, {31'h0, !(k[0] ^ k[1])}, "frame start");
      idle;
      last = s;
    end
  endtask
  // external clock frames, both clock senses, chained data after 16 clocks
  task automatic t_ext;
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      css <= 1'b1;
      drv[1] <= i[0];
      repeat (6) @(posedge pclk);
      asp_host_i.frame(i[0], 8'h5a ^ {8{i[0]}});
      check({8'h0, asp_host_i.got}, {8'h0, last, 8'h5a ^ {8{i[0]}}}, "chain frame");
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, sps, css} = '0;
    paddr = '0;
    pwdata = '0;
    drv = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_par;
    t_master;
    t_ext;
    report_and_stop;
  end
endmodule
